/* File: npc_pkg.sv */
// package: constants and types for the flash protection/configuration register block
// assumes one system clock; serial pins are sampled as plain asynchronous inputs
package npc_pkg;
    // register addresses, matched on the upper nibble of the address byte
    localparam logic [3:0] PROT_ADDR_NIB = 4'hA;
    localparam logic [3:0] CFG_ADDR_NIB = 4'hB;
    localparam logic [3:0] STAT_ADDR_NIB = 4'hC;

    // protection_reg field positions
    localparam int PR_PROTECT_LO_BIT = 7;
    localparam int PR_BLOCK_MSB = 6;
    localparam int PR_BLOCK_LSB = 2;
    localparam int PR_HW_PROTECT_BIT = 1;
    localparam int PR_PROTECT_HI_BIT = 0;
    localparam logic [7:0] PROT_RESET = 8'h7C;

    // config_reg field positions
    localparam int CR_OTP_LOCK_BIT = 7;
    localparam int CR_OTP_ACCESS_BIT = 6;
    localparam int CR_PROT_LOCK_BIT = 5;
    localparam int CR_ECC_EN_BIT = 4;
    localparam int CR_BUF_MODE_BIT = 3;
    localparam int CR_DRIVE_MSB = 2;
    localparam int CR_DRIVE_LSB = 1;
    localparam int CR_HOLD_DIS_BIT = 0;
    localparam logic [7:0] CFG_RESET_NO_BUF = 8'h14;

    // status register 3: only the write enable latch is modelled
    localparam int SR_WEL_BIT = 1;

    // opcodes
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS = 8'h04;
    localparam logic [7:0] OP_READ_STAT_A = 8'h05;
    localparam logic [7:0] OP_READ_STAT_B = 8'h0F;
    localparam logic [7:0] OP_WRITE_STAT_A = 8'h01;
    localparam logic [7:0] OP_WRITE_STAT_B = 8'h1F;
    localparam logic [7:0] OP_RESET = 8'hFF;
    localparam logic [7:0] OP_QUAD_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_LOAD = 8'h32;

    // otp area geometry
    localparam int OTP_PAGES = 10;
    localparam int OTP_PAGE_BYTES = 2112;
    localparam logic [7:0] OTP_ERASED = 8'hFF;

    // read mode geometry
    localparam int BUF_LAST_COL = 2111;
    localparam int PAGE_DATA_BYTES = 2048;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
        logic wp_n;
    } npc_pins_t;

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SKIP} npc_state_t;
endpackage : npc_pkg

/* File: npc_regs.sv */
// file: serial register bank of the flash (protection, configuration, write latch)
// assumes: spi mode 0 pins arrive unsynchronised; clk far faster than sclk;
// sys_rst stands for a power cycle.
`timescale 1ns/1ps
module npc_regs
    import npc_pkg::*;
#(
    parameter logic BUF_DEFAULT = 1'b1
) (
    input wire logic clk, // system clock 100 MHz
    input wire logic sys_rst, // synchronous reset, acts as power cycle
    input wire npc_pins_t pins, // raw serial pins
    output logic miso, // serial data out
    output logic miso_oe, // serial data out enable
    output logic [7:0] prot_reg, // protection register contents
    output logic [7:0] cfg_reg, // configuration register contents
    output logic quad_enable, // quad operation permitted; hold is a data line, protect pin still gates srp 01 protection writes
    output logic write_block, // all writes, programs and erases blocked
    output logic otp_prog_allow, // otp area may be programmed
    output logic quad_cmd, // accepted quad command, one-cycle pulse
    output logic page_load // power-up load of page 0, one-cycle pulse
);
    npc_pins_t sy1_r, sy2_r;
    logic sclk_d_r;
    npc_state_t st_r, st_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [3:0] adr_r, adr_nxt;
    logic is_wr_r, is_wr_nxt;
    logic [7:0] prot_r, prot_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic wel_r, wel_nxt;
    logic miso_r, miso_nxt;
    logic oe_r, oe_nxt;
    logic quad_en_r, quad_en_nxt;
    logic blk_r, blk_nxt;
    logic otp_ok_r, otp_ok_nxt;
    logic qcmd_r, qcmd_nxt;
    logic boot_r, boot_nxt;
    logic pload_r, pload_nxt;

    logic rise, fall, byte_done, wr_go;
    logic [7:0] rx_byte;
    logic hw_blk, prot_ok;
    logic [1:0] srp;

    // pin synchroniser; second stage is the only reader of the first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sy1_r <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, wp_n: 1'b1};
            sy2_r <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, wp_n: 1'b1};
            sclk_d_r <= 1'b0;
        end else begin
            sy1_r <= pins;
            sy2_r <= sy1_r;
            sclk_d_r <= sy2_r.sclk;
        end
    end

    function automatic logic [7:0] read_reg(input logic [3:0] nib, input logic [7:0] pr,
                                             input logic [7:0] cr, input logic wel);
        logic [7:0] v;
        v = 8'h00;
        case (nib)
            PROT_ADDR_NIB: v = pr;
            CFG_ADDR_NIB: v = cr;
            STAT_ADDR_NIB: v[SR_WEL_BIT] = wel;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    assign rise = sy2_r.sclk & ~sclk_d_r;
    assign fall = ~sy2_r.sclk & sclk_d_r;
    assign rx_byte = {sh_r[6:0], sy2_r.mosi};
    assign byte_done = rise && !sy2_r.cs_n && cnt_r == 3'd7;
    assign wr_go = byte_done && st_r == ST_WDATA;
    assign srp = {prot_r[PR_PROTECT_HI_BIT], prot_r[PR_PROTECT_LO_BIT]};
    // pin low under hardware protection blocks protection and configuration writes
    assign hw_blk = prot_r[PR_HW_PROTECT_BIT] && !sy2_r.wp_n;

    // protection register write permission
    always_comb begin
        prot_ok = 1'b0;
        if (wel_r && !cfg_r[CR_PROT_LOCK_BIT] && !hw_blk) begin
            case (srp)
                2'b00: prot_ok = 1'b1;
                2'b01: prot_ok = prot_r[PR_HW_PROTECT_BIT] || sy2_r.wp_n;
                2'b10: prot_ok = 1'b0;
                2'b11: prot_ok = 1'b1;
                default: prot_ok = 1'b0;
            endcase
        end
    end

    // serial command engine and register updates
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        adr_nxt = adr_r;
        is_wr_nxt = is_wr_r;
        prot_nxt = prot_r;
        cfg_nxt = cfg_r;
        wel_nxt = wel_r;
        miso_nxt = miso_r;
        oe_nxt = oe_r;
        qcmd_nxt = 1'b0;
        if (sy2_r.cs_n) begin
            st_nxt = ST_CMD;
            cnt_nxt = 3'd0;
            oe_nxt = 1'b0;
        end else begin
            if (rise) begin
                sh_nxt = rx_byte;
                cnt_nxt = cnt_r + 3'd1;
            end
            if (fall && st_r == ST_RDATA) begin
                // mode 0: the fall that ends the address byte must re-present bit 7,
                // otherwise the host would miss the msb of every read
                miso_nxt = tx_r[7];
                tx_nxt = {tx_r[6:0], tx_r[7]};
            end
            if (byte_done) begin
                case (st_r)
                    ST_CMD: begin
                        st_nxt = ST_SKIP;
                        case (rx_byte)
                            OP_WRITE_EN: wel_nxt = 1'b1;
                            OP_WRITE_DIS: wel_nxt = 1'b0;
                            OP_RESET: begin
                                wel_nxt = 1'b0;
                                cfg_nxt[CR_OTP_ACCESS_BIT] = 1'b0;
                            end
                            OP_READ_STAT_A, OP_READ_STAT_B: begin
                                st_nxt = ST_ADDR;
                                is_wr_nxt = 1'b0;
                            end
                            OP_WRITE_STAT_A, OP_WRITE_STAT_B: begin
                                st_nxt = ST_ADDR;
                                is_wr_nxt = 1'b1;
                            end
                            OP_QUAD_READ, OP_QUAD_LOAD: qcmd_nxt = quad_en_r;
                            default: st_nxt = ST_SKIP;
                        endcase
                    end
                    ST_ADDR: begin
                        adr_nxt = rx_byte[7:4];
                        if (is_wr_r) begin
                            st_nxt = ST_WDATA;
                        end else begin
                            st_nxt = ST_RDATA;
                            tx_nxt = read_reg(rx_byte[7:4], prot_r, cfg_r, wel_r);
                            miso_nxt = tx_nxt[7];
                            oe_nxt = 1'b1;
                        end
                    end
                    ST_WDATA: begin
                        st_nxt = ST_SKIP;
                        if (adr_r == PROT_ADDR_NIB && prot_ok) begin
                            prot_nxt = rx_byte;
                            wel_nxt = 1'b0;
                        end
                        if (adr_r == CFG_ADDR_NIB && !hw_blk) begin
                            cfg_nxt[CR_OTP_ACCESS_BIT] = rx_byte[CR_OTP_ACCESS_BIT];
                            cfg_nxt[CR_ECC_EN_BIT] = rx_byte[CR_ECC_EN_BIT];
                            cfg_nxt[CR_BUF_MODE_BIT] = rx_byte[CR_BUF_MODE_BIT];
                            cfg_nxt[CR_DRIVE_MSB:CR_DRIVE_LSB] =
                                rx_byte[CR_DRIVE_MSB:CR_DRIVE_LSB];
                            cfg_nxt[CR_HOLD_DIS_BIT] = rx_byte[CR_HOLD_DIS_BIT];
                            // lock bits only ever set, and only from otp access mode
                            if (rx_byte[CR_OTP_LOCK_BIT] && cfg_r[CR_OTP_ACCESS_BIT]) begin
                                cfg_nxt[CR_OTP_LOCK_BIT] = 1'b1;
                            end
                            if (rx_byte[CR_PROT_LOCK_BIT] && cfg_r[CR_OTP_ACCESS_BIT]
                                    && srp == 2'b11) begin
                                cfg_nxt[CR_PROT_LOCK_BIT] = 1'b1;
                            end
                        end
                    end
                    ST_RDATA: st_nxt = ST_RDATA;
                    ST_SKIP: st_nxt = ST_SKIP;
                    default: st_nxt = ST_SKIP;
                endcase
            end
        end
    end

    // derived mode flags, registered so every output is a flop
    always_comb begin
        quad_en_nxt = !prot_r[PR_HW_PROTECT_BIT];
        blk_nxt = hw_blk;
        // otp programming: access mode on, not locked, not pin-blocked
        otp_ok_nxt = cfg_r[CR_OTP_ACCESS_BIT] && !cfg_r[CR_OTP_LOCK_BIT] && !hw_blk;
        boot_nxt = 1'b0;
        pload_nxt = boot_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= ST_CMD;
            cnt_r <= 3'd0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            adr_r <= 4'h0;
            is_wr_r <= 1'b0;
            prot_r <= PROT_RESET;
            cfg_r <= CFG_RESET_NO_BUF | (BUF_DEFAULT ? 8'h08 : 8'h00);
            wel_r <= 1'b0;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
            quad_en_r <= 1'b1;
            blk_r <= 1'b0;
            otp_ok_r <= 1'b0;
            qcmd_r <= 1'b0;
            boot_r <= 1'b1;
            pload_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            adr_r <= adr_nxt;
            is_wr_r <= is_wr_nxt;
            prot_r <= prot_nxt;
            cfg_r <= cfg_nxt;
            wel_r <= wel_nxt;
            miso_r <= miso_nxt;
            oe_r <= oe_nxt;
            quad_en_r <= quad_en_nxt;
            blk_r <= blk_nxt;
            otp_ok_r <= otp_ok_nxt;
            qcmd_r <= qcmd_nxt;
            boot_r <= boot_nxt;
            pload_r <= pload_nxt;
        end
    end

    assign miso = miso_r;
    assign miso_oe = oe_r;
    assign prot_reg = prot_r;
    assign cfg_reg = cfg_r;
    assign quad_enable = quad_en_r;
    assign write_block = blk_r;
    assign otp_prog_allow = otp_ok_r;
    assign quad_cmd = qcmd_r;
    assign page_load = pload_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    prot_frozen_a: assert property (cfg_r[CR_PROT_LOCK_BIT] |=> $stable(prot_r))
        else $error("protection register changed while locked");
    pin_block_a: assert property (wr_go && hw_blk |=> $stable(prot_r) && $stable(cfg_r))
        else $error("write accepted with protect pin low");
    lock_down_a: assert property (wr_go && srp == 2'b10 |=> $stable(prot_r))
        else $error("protection register written in lock-down");
    sw_pin_a: assert property (wr_go && srp == 2'b01 && !prot_r[PR_HW_PROTECT_BIT]
        && !sy2_r.wp_n |=> $stable(prot_r))
        else $error("protection write with pin low in software mode");
    lock_gate_a: assert property ($rose(cfg_r[CR_PROT_LOCK_BIT]) |->
        $past(srp) == 2'b11 && $past(cfg_r[CR_OTP_ACCESS_BIT]))
        else $error("protection lock set without one-time mode");
    otp_sticky_a: assert property (cfg_r[CR_OTP_LOCK_BIT] |=> cfg_r[CR_OTP_LOCK_BIT]
        ##1 !otp_ok_r)
        else $error("otp lock cleared or otp still programmable");
    reset_cmd_a: assert property (byte_done && st_r == ST_CMD && rx_byte == OP_RESET |=>
        !cfg_r[CR_OTP_ACCESS_BIT] && cfg_r[CR_ECC_EN_BIT] == $past(cfg_r[CR_ECC_EN_BIT]))
        else $error("reset command mishandled otp access or ecc enable");
    quad_gate_a: assert property (quad_cmd |-> quad_en_r && $past(quad_en_r))
        else $error("quad command accepted while quad disabled");
    quad_mode_a: assert property ($rose(prot_r[PR_HW_PROTECT_BIT]) |=> !quad_en_r)
        else $error("quad still enabled under hardware protection");
    wel_need_a: assert property (wr_go && !wel_r |=> $stable(prot_r))
        else $error("protection write without write enable");
    // mode flag only: the buffer and continuous read data paths sit outside this bank
    read_mode_a: assert property (wr_go && adr_r == CFG_ADDR_NIB && !hw_blk |=>
        cfg_r[CR_BUF_MODE_BIT] == $past(rx_byte[CR_BUF_MODE_BIT]))
        else $error("read mode bit did not follow the write");
    prot_write_a: assert property (wr_go && adr_r == PROT_ADDR_NIB && prot_ok |=>
        prot_r == $past(rx_byte) && !wel_r)
        else $error("permitted protection write lost or write enable kept");
    quad_soft_a: assert property (!prot_r[PR_HW_PROTECT_BIT] |=> quad_en_r)
        else $error("quad disabled in software protection mode");
    otp_gate_a: assert property (otp_ok_r |-> $past(cfg_r[CR_OTP_ACCESS_BIT])
        && !$past(cfg_r[CR_OTP_LOCK_BIT]))
        else $error("otp programming allowed without access mode or after lock");
    block_flag_a: assert property (write_block |-> $past(prot_r[PR_HW_PROTECT_BIT]))
        else $error("write block raised without hardware protection");
    page_once_a: assert property (page_load |=> !page_load)
        else $error("power-up page load repeated");
endmodule : npc_regs

/* File: npc_host_model.sv */
// file: behavioural spi mode 0 host that drives the register bank pins
// assumes: clk is the 100 MHz system clock; sclk runs at 80 ns only inside frames
`timescale 1ns/1ps
module npc_host_model
    import npc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic miso, // device serial data out
    output npc_pins_t pins // chip select, serial clock, data in, protect pin
);
    initial begin
        pins = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, wp_n: 1'b1};
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // protect pin flips level, then the synchroniser is waited out
    task automatic flip_wp();
        @(posedge clk);
        pins.wp_n <= ~pins.wp_n;
        tick(6);
    endtask : flip_wp

    // one frame of n bytes, msb first; rd keeps the last 8 bits seen on miso
    task automatic frame(input logic [23:0] bytes, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk);
        pins.cs_n <= 1'b0;
        tick(4);
        for (int i = 0; i < n * 8; i++) begin
            pins.mosi <= bytes[23 - i];
            tick(4);
            pins.sclk <= 1'b1;
            tick(3);
            // sampled late in the high phase: in the data byte miso moves only after a falling edge
            @(negedge clk);
            rd = {rd[6:0], miso};
            @(posedge clk);
            pins.sclk <= 1'b0;
        end
        tick(4);
        pins.cs_n <= 1'b1;
        // released data line must not hold its last value
        pins.mosi <= ~pins.mosi;
        tick(6);
    endtask : frame
endmodule : npc_host_model

/* File: tb_nand_protect_config_regs.sv */
// file: self-checking bench for the protection/configuration register bank
// assumes: host model drives all serial pins; bench drives clock and reset only
`timescale 1ns/1ps
module tb_nand_protect_config_regs;
    import npc_pkg::*;
    logic clk;
    logic sys_rst;
    npc_pins_t pins;
    logic miso;
    logic miso_oe;
    logic [7:0] prot_reg;
    logic [7:0] cfg_reg;
    logic quad_enable;
    logic write_block;
    logic otp_prog_allow;
    logic quad_cmd;
    logic page_load;
    logic [7:0] rd;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int quad_seen = 0;
    int load_seen = 0;
    int oe_seen = 0;

    npc_regs #(.BUF_DEFAULT(1'b1)) npc_regs_inst (
        .clk(clk), .sys_rst(sys_rst), .pins(pins), .miso(miso), .miso_oe(miso_oe),
        .prot_reg(prot_reg), .cfg_reg(cfg_reg), .quad_enable(quad_enable),
        .write_block(write_block), .otp_prog_allow(otp_prog_allow),
        .quad_cmd(quad_cmd), .page_load(page_load)
    );
    npc_host_model npc_host_model_inst (.clk(clk), .miso(miso), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // about 40 frames of at most 207 cycles each; generous ceiling
    always @(posedge clk) begin
        cycles++;
        if (quad_cmd === 1'b1) quad_seen++;
        if (page_load === 1'b1) load_seen++;
        if (miso_oe === 1'b1) oe_seen++;
        if (cycles == 30000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : do_reset

    task automatic wen();
        npc_host_model_inst.frame({OP_WRITE_EN, 16'h0000}, 1, rd);
    endtask : wen

    task automatic wr(input logic [3:0] nib, input logic [7:0] data);
        npc_host_model_inst.frame({OP_WRITE_STAT_A, nib, 4'h0, data}, 3, rd);
    endtask : wr

    task automatic wrp(input logic [7:0] data);
        wen();
        npc_host_model_inst.frame({OP_WRITE_STAT_B, PROT_ADDR_NIB, 4'h0, data}, 3, rd);
    endtask : wrp

    task automatic quad_try();
        npc_host_model_inst.frame({OP_QUAD_READ, 16'h0000}, 1, rd);
    endtask : quad_try

    task automatic t_power_up();
        check("prot reset", prot_reg, PROT_RESET);
        check("cfg reset", cfg_reg, CFG_RESET_NO_BUF | 8'h08);
        check("quad en", {7'h00, quad_enable}, 8'h01);
        check("otp allow", {7'h00, otp_prog_allow}, 8'h00);
        check("page load", 8'(load_seen), 8'h01);
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_write_enable();
        npc_host_model_inst.flip_wp();
        wr(PROT_ADDR_NIB, 8'h00);
        check("no wel write", prot_reg, PROT_RESET);
        wrp(8'h00);
        check("pin ignored", prot_reg, 8'h00);
        npc_host_model_inst.frame({OP_READ_STAT_A, STAT_ADDR_NIB, 4'h0, 8'h00}, 3, rd);
        check("wel cleared", rd, 8'h00);
        // the data byte alone spans 64 cycles, so the driver must stand at least that long
        check("oe held", 8'(oe_seen >= 64), 8'h01);
        check("oe released", {7'h00, miso_oe}, 8'h00);
        wen();
        npc_host_model_inst.frame({OP_READ_STAT_B, STAT_ADDR_NIB, 4'h0, 8'h00}, 3, rd);
        check("wel set", rd, 8'h02);
        // uneven pattern catches a read shifted by one bit
        npc_host_model_inst.frame({OP_READ_STAT_A, CFG_ADDR_NIB, 4'h0, 8'h00}, 3, rd);
        check("cfg read", rd, CFG_RESET_NO_BUF | 8'h08);
        wr(4'h5, 8'hFF);
        check("unmapped write", prot_reg, 8'h00);
        $display("test write_enable done");
    endtask : t_write_enable

    task automatic t_soft_pin();
        npc_host_model_inst.flip_wp();
        wrp(8'h80);
        check("srp 01 pin high", prot_reg, 8'h80);
        npc_host_model_inst.flip_wp();
        wrp(8'h84);
        check("srp 01 pin low", prot_reg, 8'h80);
        npc_host_model_inst.flip_wp();
        wrp(8'h00);
        check("srp 01 reopen", prot_reg, 8'h00);
        $display("test soft_pin done");
    endtask : t_soft_pin

    task automatic t_hw_mode();
        quad_try();
        check("quad pulse", 8'(quad_seen), 8'h01);
        wrp(8'h02);
        check("hw enable", prot_reg, 8'h02);
        check("quad off", {7'h00, quad_enable}, 8'h00);
        quad_try();
        check("quad ignored", 8'(quad_seen), 8'h01);
        npc_host_model_inst.flip_wp();
        check("pin block", {7'h00, write_block}, 8'h01);
        wr(CFG_ADDR_NIB, 8'h0C);
        check("cfg blocked", cfg_reg, 8'h1C);
        wrp(8'h00);
        check("prot blocked", prot_reg, 8'h02);
        npc_host_model_inst.flip_wp();
        check("pin unblock", {7'h00, write_block}, 8'h00);
        wrp(8'h00);
        check("hw writable", prot_reg, 8'h00);
        check("quad back", {7'h00, quad_enable}, 8'h01);
        $display("test hw_mode done");
    endtask : t_hw_mode

    task automatic t_lockdown();
        wrp(8'h01);
        check("lockdown set", prot_reg, 8'h01);
        wrp(8'h00);
        check("lockdown holds", prot_reg, 8'h01);
        do_reset();
        check("power cycle", prot_reg, PROT_RESET);
        check("second load", 8'(load_seen), 8'h02);
        $display("test lockdown done");
    endtask : t_lockdown

    task automatic t_otp_lock();
        wrp(8'h81);
        check("otp mode", prot_reg, 8'h81);
        wr(CFG_ADDR_NIB, 8'h5C);
        check("otp access", cfg_reg, 8'h5C);
        check("otp allow on", {7'h00, otp_prog_allow}, 8'h01);
        wr(CFG_ADDR_NIB, 8'h7C);
        check("prot lock", cfg_reg, 8'h7C);
        wrp(8'h00);
        check("prot frozen", prot_reg, 8'h81);
        wr(CFG_ADDR_NIB, 8'hFC);
        check("otp locked", {7'h00, otp_prog_allow}, 8'h00);
        wr(CFG_ADDR_NIB, 8'hCC);
        check("lock sticky", cfg_reg, 8'hEC);
        npc_host_model_inst.frame({OP_RESET, 16'h0000}, 1, rd);
        check("reset cmd", cfg_reg, 8'hAC);
        wr(CFG_ADDR_NIB, 8'hA4);
        check("buf writable", cfg_reg, 8'hA4);
        $display("test otp_lock done");
    endtask : t_otp_lock

    initial begin
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_power_up();
        t_write_enable();
        t_soft_pin();
        t_hw_mode();
        t_lockdown();
        t_otp_lock();
        give_verdict();
    end
endmodule : tb_nand_protect_config_regs
